/* File: dv/ubs_remote_uart.sv */
// Behavioural far-end serial transmitter driving one receive line
`timescale 1ns/1ps
`default_nettype none
module ubs_remote_uart #(
  parameter int BIT_CYCLES = 320
) (
  // Clock
  input wire logic clock,
  // Frame request from the bench
  input wire logic sendReq,
  input wire logic [10:0] frameBits,
  input wire logic [3:0] frameLen,
  // Serial side
  output logic txLine,
  output logic busy
);
  // Bit 0 leaves first: start, data LSB first, optional ninth, stop
  initial
  begin
    txLine = 1'b1;
    busy = 1'b0;
    forever
    begin
      @(posedge clock);
      if (sendReq)
      begin
        busy <= 1'b1;
        for (int i = 0; i < frameLen; i++)
        begin
          txLine <= frameBits[i];
          repeat (BIT_CYCLES) @(posedge clock);
        end
        txLine <= 1'b1; // Mark level between frames
        busy <= 1'b0;
      end
    end
  end
endmodule // ubs_remote_uart
`default_nettype wire

/* File: dv/ubs_top_tb.sv */
// Self-checking bench for the baud select and receive status block
`timescale 1ns/1ps
`default_nettype none
module ubs_top_tb;
  // Timer 1 overflows every 20 cycles, so one bit is 16 x 20 cycles
  localparam int BIT_CYC = 320;
  logic clock;
  logic rstB;
  logic [10:0] sfrAddr;
  logic sfrWrEn;
  logic sfrRdEn;
  logic [7:0] sfrWrData;
  logic [7:0] sfrRdData;
  logic [1:0][1:0] uartMode;
  ubs_pkg::ubs_rx_evt_t [1:0] rxEvt;
  ubs_pkg::ubs_baud_t [1:0] txBaud;
  ubs_pkg::ubs_baud_t [1:0] rxBaud;
  logic [1:0] rxIrq;
  logic timer1Ovf;
  logic [15:0] timer2Reload;
  logic timerClockTick;
  logic timer2Ovf;
  logic sendReq;
  logic [10:0] frameBits;
  logic [3:0] frameLen;
  logic remoteLine;
  logic remoteBusy;
  logic [9:0] probe;
  int t1Count = 0;
  int cycles = 0;
  int failCount = 0;
  int checked = 0;

  ubs_top dut_u (.clock(clock), .rst_b(rstB), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .uartMode(uartMode),
    .rxEvt(rxEvt), .rxdPin({2{remoteLine}}), .txBaud(txBaud), .rxBaud(rxBaud),
    .rxIrq(rxIrq), .timer1Ovf(timer1Ovf), .timer2Reload(timer2Reload),
    .timerClockTick(timerClockTick), .timer2Ovf(timer2Ovf));
  ubs_remote_uart #(.BIT_CYCLES(BIT_CYC)) remote_u (.clock(clock), .sendReq(sendReq),
    .frameBits(frameBits), .frameLen(frameLen), .txLine(remoteLine), .busy(remoteBusy));

  // Pulses by index: rx0 bit/sample 0/1, rx1 2/3, tx0 4/5, t2 ovf 6, timer_clock 7, tx1 8/9
  assign probe = {txBaud[1], timerClockTick, timer2Ovf, txBaud[0], rxBaud[1], rxBaud[0]};

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Timer 1 stand-in and hang guard
  always @(posedge clock)
  begin
    t1Count <= (t1Count == 19) ? 0 : t1Count + 1;
    timer1Ovf <= (t1Count == 19);
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      failCount++;
      stopTest();
    end
  end

  task automatic stopTest();
    if (failCount == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkNum(input string what, input int exp, input int got);
    checked++;
    if (got != exp)
    begin
      failCount++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic regWrite(input logic [10:0] a, input logic [7:0] d);
    @(posedge clock);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge clock);
    sfrWrEn <= 1'b0;
  endtask

  // Read strobe held for one sampled edge, data taken once it has settled
  task automatic rdChk(input string what, input logic [10:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clock);
    sfrRdEn <= 1'b0;
    @(negedge clock);
    chkByte(what, exp, sfrRdData);
  endtask

  // Cycles between two pulses of one probe; bounded so a dead tick cannot hang
  task automatic rate(input string what, input int idx, input int exp);
    int w;
    int n;
    w = 0;
    n = 1;
    @(negedge clock);
    while (probe[idx] !== 1'b1 && w < 5000)
    begin
      @(negedge clock);
      w++;
    end
    @(negedge clock);
    while (probe[idx] !== 1'b1 && n < 5000)
    begin
      @(negedge clock);
      n++;
    end
    chkNum(what, exp, n);
  endtask

  task automatic evt(input int u, input logic fe, input logic sb, input logic b8);
    @(posedge clock);
    rxEvt[u].frameEnd <= fe;
    rxEvt[u].stopBit <= sb;
    rxEvt[u].bit8Arrive <= b8;
    @(posedge clock);
    rxEvt[u].frameEnd <= 1'b0;
    rxEvt[u].bit8Arrive <= 1'b0;
  endtask

  task automatic sendFrame(input logic [10:0] bits, input logic [3:0] len);
    int w;
    w = 0;
    @(posedge clock);
    frameBits <= bits;
    frameLen <= len;
    sendReq <= 1'b1;
    @(posedge clock);
    sendReq <= 1'b0;
    @(negedge clock);
    while (remoteBusy !== 1'b0 && w < 5000)
    begin
      @(negedge clock);
      w++;
    end
    repeat (20) @(posedge clock);
  endtask

  task automatic tReset();
    rdChk("timer2 control", ubs_pkg::OFS_TIMER2_CONTROL, 8'h00);
    rdChk("timer2 mode", ubs_pkg::OFS_TIMER2_MODE, 8'h00);
    rdChk("status0", ubs_pkg::OFS_UART0_STATUS, 8'h00);
    rdChk("status1", ubs_pkg::OFS_UART1_STATUS, 8'h00);
    rdChk("system config", ubs_pkg::OFS_SYSTEM_CONFIG, 8'h00);
    rdChk("unmapped", 11'h421, 8'h00);
  endtask

  task automatic tPrescale();
    int n;
    n = 0;
    regWrite(ubs_pkg::OFS_SYSTEM_CONFIG, 8'h00);
    rate("timer_clock div4", 7, 4);
    regWrite(ubs_pkg::OFS_SYSTEM_CONFIG, 8'h04);
    rate("timer_clock div16", 7, 16);
    regWrite(ubs_pkg::OFS_SYSTEM_CONFIG, 8'h08);
    rate("timer_clock div64", 7, 64);
    regWrite(ubs_pkg::OFS_SYSTEM_CONFIG, 8'h0C);
    repeat (70) @(posedge clock);
    repeat (200)
    begin
      @(negedge clock);
      n += int'(timerClockTick === 1'b1);
    end
    chkNum("timer_clock reserved", 0, n);
    regWrite(ubs_pkg::OFS_SYSTEM_CONFIG, 8'h00);
  endtask

  task automatic tFixed();
    uartMode[1] <= ubs_pkg::MODE_SHIFT;
    rate("mode0 sample", 3, 1);
    rate("mode0 bit", 2, 16);
    @(posedge clock);
    uartMode[1] <= ubs_pkg::MODE_FIXED9;
    // Let the last mode 0 sample pulse drain before timing mode 2
    repeat (4) @(posedge clock);
    rate("mode2 sample", 3, 2);
    rate("mode2 bit", 2, 32);
  endtask

  // Reload FFF0 gives 16 timer ticks of 4 cycles per overflow
  task automatic tTimer2();
    @(posedge clock);
    timer2Reload <= 16'hFFF0; // Reload kept inside the 16-bit range
    uartMode <= {ubs_pkg::MODE_UART9, ubs_pkg::MODE_UART8};
    regWrite(ubs_pkg::OFS_TIMER2_CONTROL, 8'h20);
    rate("t2 overflow", 6, 64);
    rate("rx0 sample t2", 1, 64);
    rate("rx0 bit t2", 0, 1024);
    rate("tx0 sample t1", 5, 20);
    rate("tx0 bit t1", 4, 320);
    rate("rx1 sample t1", 3, 20);
    regWrite(ubs_pkg::OFS_TIMER2_MODE, 8'h10);
    rate("tx1 sample t2", 9, 64);
    rate("tx1 bit t2", 8, 1024);
    @(posedge clock);
    timer2Reload <= 16'hFFFF;
    repeat (200) @(posedge clock);
    rate("rx0 bit fastest", 0, 64);
    regWrite(ubs_pkg::OFS_TIMER2_CONTROL, 8'h00);
    regWrite(ubs_pkg::OFS_TIMER2_MODE, 8'h00);
  endtask

  task automatic tStatus();
    evt(1, 1'b1, 1'b1, 1'b0);
    rdChk("good stop", ubs_pkg::OFS_UART1_STATUS, 8'h00);
    evt(1, 1'b1, 1'b0, 1'b0);
    rdChk("framing", ubs_pkg::OFS_UART1_STATUS, 8'h08);
    chkByte("irq masked", 8'h00, {7'h00, rxIrq[1]});
    regWrite(ubs_pkg::OFS_UART1_STATUS, 8'h09);
    @(negedge clock);
    chkByte("irq enabled", 8'h01, {7'h00, rxIrq[1]});
    regWrite(ubs_pkg::OFS_UART1_STATUS, 8'h01);
    rdChk("framing clear", ubs_pkg::OFS_UART1_STATUS, 8'h01);
    chkByte("irq idle", 8'h00, {7'h00, rxIrq[1]});
    evt(1, 1'b0, 1'b0, 1'b1);
    rdChk("no overrun", ubs_pkg::OFS_UART1_STATUS, 8'h01);
    @(posedge clock);
    rxEvt[1].rxDone <= 1'b1;
    evt(1, 1'b0, 1'b0, 1'b1);
    rxEvt[1].rxDone <= 1'b0;
    rdChk("overrun", ubs_pkg::OFS_UART1_STATUS, 8'h03);
    chkByte("irq overrun", 8'h01, {7'h00, rxIrq[1]});
    regWrite(ubs_pkg::OFS_UART1_STATUS, 8'hFF);
    rdChk("status mask", ubs_pkg::OFS_UART1_STATUS, 8'h0F);
    regWrite(ubs_pkg::OFS_UART1_STATUS, 8'h00);
    evt(0, 1'b1, 1'b0, 1'b0);
    rdChk("framing0", ubs_pkg::OFS_UART0_STATUS, 8'h08);
    chkByte("irq0 masked", 8'h00, {7'h00, rxIrq[0]});
    rdChk("status1 apart", ubs_pkg::OFS_UART1_STATUS, 8'h00);
  endtask

  // Both receivers hear the far end and sample on timer 1
  task automatic tBreak();
    @(posedge clock);
    uartMode[1] <= ubs_pkg::MODE_UART8;
    sendFrame(11'h300, 4'hA);
    rdChk("data 80", ubs_pkg::OFS_UART1_STATUS, 8'h00);
    regWrite(ubs_pkg::OFS_UART1_STATUS, 8'h01);
    sendFrame(11'h000, 4'hA);
    rdChk("break mode1", ubs_pkg::OFS_UART1_STATUS, 8'h05);
    chkByte("irq break", 8'h01, {7'h00, rxIrq[1]});
    rdChk("break uart0", ubs_pkg::OFS_UART0_STATUS, 8'h0C);
    regWrite(ubs_pkg::OFS_UART1_STATUS, 8'h00);
    uartMode <= {ubs_pkg::MODE_UART9, ubs_pkg::MODE_UART9};
    sendFrame(11'h600, 4'hB);
    rdChk("nine low mode3", ubs_pkg::OFS_UART1_STATUS, 8'h00);
    rdChk("break sticky", ubs_pkg::OFS_UART0_STATUS, 8'h0C);
  endtask

  initial
  begin
    rstB = 1'b0;
    sfrAddr = 11'h000;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b0;
    sfrWrData = 8'h00;
    uartMode = '0;
    rxEvt = '0;
    timer2Reload = 16'h0000;
    sendReq = 1'b0;
    frameBits = 11'h000;
    frameLen = 4'h0;
    repeat (4) @(posedge clock);
    rstB <= 1'b1;
    tReset();
    tPrescale();
    tFixed();
    tTimer2();
    tStatus();
    tBreak();
    stopTest();
  end
endmodule // ubs_top_tb
`default_nettype wire

/* File: logic/ubs_baud_gen.sv */
// Sampling and bit enables for one UART direction
`timescale 1ns/1ps
`default_nettype none
module ubs_baud_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Source selection
  input wire logic [1:0] mode,
  input wire logic useTimer2,
  input wire logic timer1Ovf,
  input wire logic timer2Ovf,
  // Rate enables
  output ubs_pkg::ubs_baud_t baud
);
  logic [3:0] sampleCnt_q;
  logic halfCnt_q;
  logic sample_d;

  // Sample enable source by mode
  always_comb
  begin
    unique case (mode)
      ubs_pkg::MODE_SHIFT: sample_d = 1'b1; // Osc rate sampling
      ubs_pkg::MODE_FIXED9: sample_d = (halfCnt_q == ubs_pkg::MODE2_SAMPLE_LAST);
      default: sample_d = useTimer2 ? timer2Ovf : timer1Ovf;
    endcase
  end

  // Halving divider for the fixed 9-bit mode
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      halfCnt_q <= 1'b0;
    else
      halfCnt_q <= halfCnt_q + 1'b1;
  end

  // Sixteen samples per bit; bit enable on the last one
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sampleCnt_q <= 4'h0;
      baud <= '0;
    end
    else
    begin
      baud.sampleTick <= sample_d;
      baud.bitTick <= sample_d && (sampleCnt_q == ubs_pkg::SAMPLES_LAST);
      if (sample_d)
        sampleCnt_q <= sampleCnt_q + 4'h1;
    end
  end
endmodule // ubs_baud_gen
`default_nettype wire

/* File: logic/ubs_break_det.sv */
// Start-of-break detector watching one receive line
`timescale 1ns/1ps
`default_nettype none
module ubs_break_det (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Line and timing
  input wire logic rxLevel,
  input wire logic sampleTick,
  input wire logic [1:0] mode,
  // Event
  output logic breakSet
);
  logic [7:0] lowCnt_q;
  logic [7:0] limit;

  // Nine or ten bit times of zero, start and data positions without the stop position
  always_comb
  begin
    unique case (mode)
      ubs_pkg::MODE_UART8: limit = ubs_pkg::BREAK_SAMPLES_8;
      ubs_pkg::MODE_SHIFT: limit = 8'h00;
      default: limit = ubs_pkg::BREAK_SAMPLES_9;
    endcase
  end

  // Runs apart from the shifter; saturates so one break sets once
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lowCnt_q <= 8'h00;
      breakSet <= 1'b0;
    end
    else
    begin
      breakSet <= 1'b0;
      if (rxLevel || limit == 8'h00)
        lowCnt_q <= 8'h00;
      else if (sampleTick && lowCnt_q != limit)
      begin
        lowCnt_q <= lowCnt_q + 8'h01;
        breakSet <= (lowCnt_q + 8'h01) == limit;
      end
    end
  end

  property p_break_count;
    @(posedge clock) disable iff (!rst_b)
    breakSet |-> (lowCnt_q == limit) && !$past(rxLevel);
  endproperty
  a_break_count: assert property (p_break_count) else $error("break flagged early");
endmodule // ubs_break_det
`default_nettype wire

/* File: logic/ubs_pkg.sv */
// Shared constants and carrier types for the UART baud select and status block
package ubs_pkg;
  // Register map on the special function bus
  localparam int ADDR_W = 11;
  localparam logic [10:0] OFS_TIMER2_CONTROL = 11'h418;
  localparam logic [10:0] OFS_TIMER2_MODE = 11'h419;
  localparam logic [10:0] OFS_UART0_STATUS = 11'h424;
  localparam logic [10:0] OFS_UART1_STATUS = 11'h425;
  localparam logic [10:0] OFS_SYSTEM_CONFIG = 11'h440;

  // Field positions
  localparam int BIT_RX_USES_T2 = 5;
  localparam int BIT_TX_USES_T2 = 4;
  localparam int BIT_PRESCALE_HI = 3;
  localparam int BIT_PRESCALE_LO = 2;
  localparam int BIT_FRAMING = 3;
  localparam int BIT_BREAK = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_STINT = 0;
  localparam logic [7:0] STATUS_MASK = 8'h0F;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // Prescaler codes and terminal counts (N - 1)
  localparam logic [1:0] PRE_DIV4 = 2'h0;
  localparam logic [1:0] PRE_DIV16 = 2'h1;
  localparam logic [1:0] PRE_DIV64 = 2'h2;
  localparam logic [1:0] PRE_RSVD = 2'h3;
  localparam logic [5:0] PRE_LAST4 = 6'h03;
  localparam logic [5:0] PRE_LAST16 = 6'h0F;
  localparam logic [5:0] PRE_LAST64 = 6'h3F;

  // Serial modes
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_FIXED9 = 2'h2;
  localparam logic [1:0] MODE_UART9 = 2'h3;

  // Timing: sample ticks per bit, fixed-mode sample divider, timer 2 top
  localparam logic [3:0] SAMPLES_LAST = 4'hF;
  localparam logic [0:0] MODE2_SAMPLE_LAST = 1'h1;
  localparam logic [15:0] T2_TOP = 16'hFFFF;
  localparam int BITS_BREAK_8 = 9;
  localparam int BITS_BREAK_9 = 10;
  localparam logic [7:0] BREAK_SAMPLES_8 = 8'(BITS_BREAK_8 * 16);
  localparam logic [7:0] BREAK_SAMPLES_9 = 8'(BITS_BREAK_9 * 16);

  // Receiver events from the shifter of one UART
  typedef struct packed {
    logic frameEnd;
    logic stopBit;
    logic bit8Arrive;
    logic rxDone;
  } ubs_rx_evt_t;

  // Rate enables for one UART direction
  typedef struct packed {
    logic sampleTick;
    logic bitTick;
  } ubs_baud_t;
endpackage

/* File: logic/ubs_top.sv */
// Baud source selection, timer prescaler and extended receive status for two UARTs
`timescale 1ns/1ps
`default_nettype none
module ubs_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Special function register port
  input wire logic [10:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // UART side
  input wire logic [1:0][1:0] uartMode,
  input wire ubs_pkg::ubs_rx_evt_t [1:0] rxEvt,
  input wire logic [1:0] rxdPin,
  output ubs_pkg::ubs_baud_t [1:0] txBaud,
  output ubs_pkg::ubs_baud_t [1:0] rxBaud,
  output logic [1:0] rxIrq,
  // Timer side
  input wire logic timer1Ovf,
  input wire logic [15:0] timer2Reload,
  output logic timerClockTick,
  output logic timer2Ovf
);
  logic [7:0] t2Control_q;
  logic [7:0] t2Mode_q;
  logic [7:0] sysConfig_q;
  logic [1:0][7:0] status_q;
  logic [1:0] prescSel;
  logic [5:0] prescCnt_q;
  logic [5:0] prescLast;
  logic [15:0] t2Cnt_q;
  logic [1:0] rxUsesT2;
  logic [1:0] txUsesT2;
  logic [1:0] rxSync1_q;
  logic [1:0] rxSync2_q;
  logic [1:0] rxSync3_q;
  logic [1:0] rxLevel_q;
  logic [1:0] breakSet;

  // Register address match, shared by write and read decode
  function automatic logic addrHit(input logic [10:0] addr, input logic [10:0] ofs);
    addrHit = (addr == ofs);
  endfunction

  // Timer 2 select bits: UART0 in control, UART1 in mode register
  assign rxUsesT2 = {t2Mode_q[ubs_pkg::BIT_RX_USES_T2], t2Control_q[ubs_pkg::BIT_RX_USES_T2]};
  assign txUsesT2 = {t2Mode_q[ubs_pkg::BIT_TX_USES_T2], t2Control_q[ubs_pkg::BIT_TX_USES_T2]};
  assign prescSel = {sysConfig_q[ubs_pkg::BIT_PRESCALE_HI], sysConfig_q[ubs_pkg::BIT_PRESCALE_LO]};

  // Control registers; bits not used here still read back for other blocks
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      t2Control_q <= ubs_pkg::RST_REG;
      t2Mode_q <= ubs_pkg::RST_REG;
      sysConfig_q <= ubs_pkg::RST_REG;
    end
    else if (sfrWrEn)
    begin
      if (addrHit(sfrAddr, ubs_pkg::OFS_TIMER2_CONTROL))
        t2Control_q <= sfrWrData;
      if (addrHit(sfrAddr, ubs_pkg::OFS_TIMER2_MODE))
        t2Mode_q <= sfrWrData;
      if (addrHit(sfrAddr, ubs_pkg::OFS_SYSTEM_CONFIG))
        sysConfig_q <= sfrWrData;
    end
  end

  // Read data registered on the read strobe; unmapped reads give zero
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sfrRdData <= 8'h00;
    else if (sfrRdEn)
    begin
      if (addrHit(sfrAddr, ubs_pkg::OFS_TIMER2_CONTROL))
        sfrRdData <= t2Control_q;
      else if (addrHit(sfrAddr, ubs_pkg::OFS_TIMER2_MODE))
        sfrRdData <= t2Mode_q;
      else if (addrHit(sfrAddr, ubs_pkg::OFS_SYSTEM_CONFIG))
        sfrRdData <= sysConfig_q;
      else if (addrHit(sfrAddr, ubs_pkg::OFS_UART0_STATUS))
        sfrRdData <= status_q[0];
      else if (addrHit(sfrAddr, ubs_pkg::OFS_UART1_STATUS))
        sfrRdData <= status_q[1];
      else
        sfrRdData <= 8'h00;
    end
  end

  // Prescaler terminal count; reserved code stops the timer clock
  always_comb
  begin
    unique case (prescSel)
      ubs_pkg::PRE_DIV4: prescLast = ubs_pkg::PRE_LAST4;
      ubs_pkg::PRE_DIV16: prescLast = ubs_pkg::PRE_LAST16;
      ubs_pkg::PRE_DIV64: prescLast = ubs_pkg::PRE_LAST64;
      ubs_pkg::PRE_RSVD: prescLast = 6'h00;
    endcase
  end

  // Shared timer clock enable, never faster than osc/4
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prescCnt_q <= 6'h00;
      timerClockTick <= 1'b0;
    end
    else if (prescSel == ubs_pkg::PRE_RSVD)
    begin
      prescCnt_q <= 6'h00;
      timerClockTick <= 1'b0;
    end
    else
    begin
      timerClockTick <= (prescCnt_q >= prescLast);
      prescCnt_q <= (prescCnt_q >= prescLast) ? 6'h00 : prescCnt_q + 6'h01;
    end
  end

  // Timer 2 as up-counting baud generator over the full 16-bit range
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      t2Cnt_q <= 16'h0000;
      timer2Ovf <= 1'b0;
    end
    else
    begin
      timer2Ovf <= 1'b0;
      // Idle timer parks at its reload, so the first period after selection is whole
      if (!(|rxUsesT2 || |txUsesT2))
        t2Cnt_q <= timer2Reload;
      else if (timerClockTick)
      begin
        if (t2Cnt_q == ubs_pkg::T2_TOP)
        begin
          t2Cnt_q <= timer2Reload; // Reload bounds set by software
          timer2Ovf <= 1'b1;
        end
        else
          t2Cnt_q <= t2Cnt_q + 16'h0001;
      end
    end
  end

  // Line synchroniser: first stage feeds only the second
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxSync1_q <= 2'h3;
      rxSync2_q <= 2'h3;
      rxSync3_q <= 2'h3;
      rxLevel_q <= 2'h3;
    end
    else
    begin
      rxSync1_q <= rxdPin;
      rxSync2_q <= rxSync1_q;
      rxSync3_q <= rxSync2_q;
      for (int i = 0; i < 2; i++)
        if (rxSync2_q[i] == rxSync3_q[i])
          rxLevel_q[i] <= rxSync3_q[i];
    end
  end

  // Per-UART rate generation, break detect and status
  for (genvar u = 0; u < 2; u++)
  begin : g_uart
    ubs_baud_gen u_tx (
      .clock(clock),
      .rst_b(rst_b),
      .mode(uartMode[u]),
      .useTimer2(txUsesT2[u]),
      .timer1Ovf(timer1Ovf),
      .timer2Ovf(timer2Ovf),
      .baud(txBaud[u])
    );
    ubs_baud_gen u_rx (
      .clock(clock),
      .rst_b(rst_b),
      .mode(uartMode[u]),
      .useTimer2(rxUsesT2[u]),
      .timer1Ovf(timer1Ovf),
      .timer2Ovf(timer2Ovf),
      .baud(rxBaud[u])
    );
    ubs_break_det u_brk (
      .clock(clock),
      .rst_b(rst_b),
      .rxLevel(rxLevel_q[u]),
      .sampleTick(rxBaud[u].sampleTick),
      .mode(uartMode[u]),
      .breakSet(breakSet[u])
    );

    // Sticky flags: hardware set wins over a software clear
    always_ff @(posedge clock or negedge rst_b)
    begin
      if (!rst_b)
        status_q[u] <= ubs_pkg::RST_REG;
      else
      begin
        if (sfrWrEn && addrHit(sfrAddr, u == 0 ? ubs_pkg::OFS_UART0_STATUS
                                               : ubs_pkg::OFS_UART1_STATUS))
          status_q[u] <= sfrWrData & ubs_pkg::STATUS_MASK;
        if (rxEvt[u].frameEnd && !rxEvt[u].stopBit)
          status_q[u][ubs_pkg::BIT_FRAMING] <= 1'b1;
        if (breakSet[u])
          status_q[u][ubs_pkg::BIT_BREAK] <= 1'b1;
        if (rxEvt[u].bit8Arrive && rxEvt[u].rxDone)
          status_q[u][ubs_pkg::BIT_OVERRUN] <= 1'b1;
      end
    end

    // Receive request merges done flag with enabled status flags
    assign rxIrq[u] = rxEvt[u].rxDone || (status_q[u][ubs_pkg::BIT_STINT] &&
                      |status_q[u][ubs_pkg::BIT_FRAMING:ubs_pkg::BIT_OVERRUN]);

    property p_framing;
      @(posedge clock) disable iff (!rst_b)
      rxEvt[u].frameEnd && !rxEvt[u].stopBit |=> status_q[u][ubs_pkg::BIT_FRAMING];
    endproperty
    a_framing: assert property (p_framing) else $error("framing flag not set");

    property p_overrun;
      @(posedge clock) disable iff (!rst_b)
      rxEvt[u].bit8Arrive && rxEvt[u].rxDone |=> status_q[u][ubs_pkg::BIT_OVERRUN] ##1
      (status_q[u][ubs_pkg::BIT_OVERRUN] || $past(sfrWrEn));
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun flag lost");

    property p_irq;
      @(posedge clock) disable iff (!rst_b)
      status_q[u][ubs_pkg::BIT_STINT] && $rose(status_q[u][ubs_pkg::BIT_BREAK]) |-> rxIrq[u];
    endproperty
    a_irq: assert property (p_irq) else $error("status interrupt missing");

    property p_mode0;
      @(posedge clock) disable iff (!rst_b)
      uartMode[u] == ubs_pkg::MODE_SHIFT ##1 uartMode[u] == ubs_pkg::MODE_SHIFT
      |-> rxBaud[u].sampleTick;
    endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0 sample rate wrong");

    property p_bit_spacing;
      @(posedge clock) disable iff (!rst_b)
      rxBaud[u].bitTick && uartMode[u] == ubs_pkg::MODE_SHIFT ##1
      uartMode[u] == ubs_pkg::MODE_SHIFT [*8] |-> !rxBaud[u].bitTick [*8];
    endproperty
    a_bit_spacing: assert property (p_bit_spacing) else $error("bit tick too soon");

    property p_t2_route;
      @(posedge clock) disable iff (!rst_b)
      timer2Ovf && rxUsesT2[u] && uartMode[u] == ubs_pkg::MODE_UART8 ##1
      uartMode[u] == ubs_pkg::MODE_UART8 |-> rxBaud[u].sampleTick;
    endproperty
    a_t2_route: assert property (p_t2_route) else $error("timer 2 not routed");
  end

  property p_presc4;
    @(posedge clock) disable iff (!rst_b)
    timerClockTick && prescSel == ubs_pkg::PRE_DIV4 |=> !timerClockTick [*3];
  endproperty
  a_presc4: assert property (p_presc4) else $error("timer clock above osc/4");

  property p_presc_rsvd;
    @(posedge clock) disable iff (!rst_b)
    prescSel == ubs_pkg::PRE_RSVD ##1 prescSel == ubs_pkg::PRE_RSVD |-> !timerClockTick;
  endproperty
  a_presc_rsvd: assert property (p_presc_rsvd) else $error("reserved prescale ticks");

  property p_t2_reload;
    @(posedge clock) disable iff (!rst_b)
    timer2Ovf |-> t2Cnt_q == $past(timer2Reload);
  endproperty
  a_t2_reload: assert property (p_t2_reload) else $error("timer 2 reload wrong");
endmodule // ubs_top
`default_nettype wire
